/* File: rtl/ucg_defines.svh */
// Constants of the group on/off controller: times, presets, offsets and field positions.
// Assumes a single 50 MHz system clock and a 32-bit register bus.
`ifndef UCG_DEFINES_SVH
`define UCG_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define UCG_CLK_HZ 50000000
`define UCG_GAP_TIME_S 6
`define UCG_HOLD_TIME_S 3
`define UCG_IDLE_TIME_S 30
`define UCG_FLASH_TIME_MS 125
`define UCG_MS_PER_S 1000

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define UCG_NUNIT 16
`define UCG_AW 4
`define UCG_NKEY 18
`define UCG_KEY_GRP_PWR 16
`define UCG_KEY_GRP_MODE 17
`define UCG_CNT_W 32
`define UCG_SP_W 5
`define UCG_NEV 4

// ----------------------------------------------------------------
// Mode presets in degrees Celsius
// ----------------------------------------------------------------
`define UCG_COOL_SP 5'h14
`define UCG_HEAT_SP 5'h1C

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UCG_BUS_AW 5
`define UCG_OFS_STATUS 5'h00
`define UCG_OFS_MASK 5'h04
`define UCG_OFS_CONFIG 5'h08
`define UCG_OFS_STATE 5'h0C
`define UCG_OFS_UNITS 5'h10

// ----------------------------------------------------------------
// Event bits of STATUS and MASK
// ----------------------------------------------------------------
`define UCG_EV_CMD 0
`define UCG_EV_REFUSED 1
`define UCG_EV_FAULT 2
`define UCG_EV_MODE 3

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define UCG_CFG_SLEEP_EN 0
`define UCG_CFG_RESET 1'h1
`define UCG_ST_HEAT 4
`define UCG_ST_GAP 5
`define UCG_ST_DARK 6
`define UCG_ST_NVM 7

`endif

/* File: rtl/ucg_pkg.sv */
// Types of the group on/off controller.
// Assumes ucg_defines.svh is on the include path.
`include "ucg_defines.svh"

package ucg_pkg;

  // Group power key: idle, held, press already acted upon (long press or wake press).
  typedef enum logic [1:0] {
    GK_IDLE = 2'h0,
    GK_HELD = 2'h1,
    GK_DONE = 2'h3
  } ucg_gk_t;

  typedef struct packed {
    logic [`UCG_NKEY-1:0] s1;
    logic [`UCG_NKEY-1:0] s2;
    logic [`UCG_NKEY-1:0] s3;
    logic [`UCG_NKEY-1:0] key;
    ucg_gk_t gk;
    logic [`UCG_CNT_W-1:0] hold;
    logic [`UCG_CNT_W-1:0] gap;
    logic gap_busy;
    logic [`UCG_CNT_W-1:0] idle;
    logic dark;
    logic [`UCG_CNT_W-1:0] flash_cnt;
    logic flash;
    logic heat_mode;
    logic [`UCG_AW-1:0] last_addr;
    logic [`UCG_NUNIT-1:0] heat_d;
    logic [`UCG_NUNIT-1:0] fault_d;
    logic cmd_valid;
    logic cmd_all;
    logic [`UCG_AW-1:0] cmd_addr;
    logic cmd_on;
    logic cmd_mode_set;
    logic cmd_heat;
    logic [`UCG_SP_W-1:0] cmd_setpoint;
    logic [`UCG_NUNIT-1:0] tag_blue;
    logic [`UCG_NUNIT-1:0] tag_red;
    logic grp_blue;
    logic grp_red;
    logic pwr_light;
    logic ack;
    logic [31:0] rdata;
    logic [`UCG_NEV-1:0] status;
    logic [`UCG_NEV-1:0] mask;
    logic sleep_en;
  } ucg_state_t;

endpackage : ucg_pkg

/* File: rtl/ucg_top.sv */
// Key and indicator logic of a group on/off controller for sixteen indoor units.
// Assumes debounced-by-us key pins, unit status from network logic on the same clock,
// and an Avalon-MM master on the register port.
//
// Contract
// - Command at most sixteen indoor units at addresses zero to fifteen.
// - Tags map in four rows of four to addresses 0 through 15.
// - Tag lights blue for cooling or fan, red for heating.
// - A unit key toggles that unit: running goes off, stopped goes on.
// - Changes requested within six seconds of the last accepted change are ignored.
// - A faulty unit flashes its tag red quickly.
// - After key inactivity all lights go dark; any key press wakes.
// - Group mode key sets all units to one mode, cooling or heating only.
// - Cooling is 20 degrees, high fan, blue; heating 28 degrees, high fan, red.
// - Mode changed by another device updates the tag colour to actual mode.
// - Holding group power key three seconds or more toggles all units.
// - Shorter group power press toggles the most recently controlled unit.
// - Fast flash of group power light shows parameter memory fault.
// - Mode presets cannot be changed from the controller keys.
// - Duplicate network addresses are seen as a single unit.
`timescale 1ns/1ps
`default_nettype none

module ucg_top
  import ucg_pkg::*;
#(
  parameter int unsigned GAP_CYC = `UCG_GAP_TIME_S * `UCG_CLK_HZ,
  parameter int unsigned HOLD_CYC = `UCG_HOLD_TIME_S * `UCG_CLK_HZ,
  parameter int unsigned IDLE_CYC = `UCG_IDLE_TIME_S * `UCG_CLK_HZ,
  parameter int unsigned FLASH_CYC = `UCG_FLASH_TIME_MS * (`UCG_CLK_HZ / `UCG_MS_PER_S)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`UCG_NUNIT-1:0] unit_key,
  input wire logic grp_pwr_key,
  input wire logic grp_mode_key,
  input wire logic [`UCG_NUNIT-1:0] unit_present,
  input wire logic [`UCG_NUNIT-1:0] unit_running,
  input wire logic [`UCG_NUNIT-1:0] unit_heat,
  input wire logic [`UCG_NUNIT-1:0] unit_fault,
  input wire logic nvm_fault,
  output logic cmd_valid,
  output logic cmd_all,
  output logic [`UCG_AW-1:0] cmd_addr,
  output logic cmd_on,
  output logic cmd_mode_set,
  output logic cmd_heat,
  output logic [`UCG_SP_W-1:0] cmd_setpoint,
  output logic cmd_fan_high,
  output logic [`UCG_NUNIT-1:0] tag_blue,
  output logic [`UCG_NUNIT-1:0] tag_red,
  output logic grp_blue,
  output logic grp_red,
  output logic pwr_light,
  input wire logic [`UCG_BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Row and column of a tag give its network address.
  function automatic logic [`UCG_AW-1:0] tag_addr(input int unsigned tag);
    logic [`UCG_AW-1:0] t;
    t = tag[`UCG_AW-1:0];
    return {t[3:2], t[1:0]};
  endfunction : tag_addr

  function automatic logic sel(input logic [`UCG_BUS_AW-1:0] a, input logic [`UCG_BUS_AW-1:0] ofs);
    return a == ofs;
  endfunction : sel

  ucg_state_t q;
  ucg_state_t n;
  logic [`UCG_NKEY-1:0] press;
  logic [`UCG_NKEY-1:0] release_k;
  logic [`UCG_NUNIT-1:0] run_now;
  logic [`UCG_NUNIT-1:0] heat_now;
  logic [`UCG_NUNIT-1:0] fault_now;
  logic req_long;
  logic req_short;
  logic req_mode;
  logic req_unit;
  logic [`UCG_AW-1:0] unit_sel;
  logic wake;
  logic issue;
  logic [`UCG_NEV-1:0] ev;
  logic bus_req;

  // The network reports one record per address, so a duplicate address shows as one unit.
  assign run_now = unit_present & unit_running;
  assign heat_now = unit_present & unit_heat;
  assign fault_now = unit_present & unit_fault;
  assign bus_req = avs_read | avs_write;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    // Three-stage key synchronisers; a change counts when stages two and three agree.
    n.s1 = {grp_mode_key, grp_pwr_key, unit_key};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.key = (q.s2 & q.s3) | (q.key & (q.s2 ^ q.s3));
    press = n.key & ~q.key;
    release_k = q.key & ~n.key;
    wake = q.dark && (|press);

    // Power saving: any key press restarts the idle count and lights up again.
    if (|press) begin
      n.idle = '0;
      n.dark = 1'b0;
    end else if (q.idle != IDLE_CYC) begin
      n.idle = q.idle + 1'b1;
    end else begin
      n.dark = q.sleep_en;
    end

    n.flash_cnt = q.flash_cnt + 1'b1;
    if (q.flash_cnt == FLASH_CYC - 1) begin
      n.flash_cnt = '0;
      n.flash = ~q.flash;
    end

    // Group power key: long press acts once at the threshold, short press on release.
    req_long = 1'b0;
    req_short = 1'b0;
    n.hold = '0;
    case (q.gk)
      GK_IDLE: begin
        if (press[`UCG_KEY_GRP_PWR]) begin
          n.gk = wake ? GK_DONE : GK_HELD;
        end
      end
      GK_HELD: begin
        n.hold = q.hold + 1'b1;
        if (release_k[`UCG_KEY_GRP_PWR]) begin
          req_short = 1'b1;
          n.gk = GK_IDLE;
        end else if (q.hold == HOLD_CYC - 1) begin
          req_long = 1'b1;
          n.gk = GK_DONE;
        end
      end
      GK_DONE: begin
        if (!n.key[`UCG_KEY_GRP_PWR]) begin
          n.gk = GK_IDLE;
        end
      end
      default: begin
        n.gk = GK_IDLE;
      end
    endcase

    req_mode = press[`UCG_KEY_GRP_MODE] && !wake;
    req_unit = 1'b0;
    unit_sel = '0;
    for (int i = `UCG_NUNIT - 1; i >= 0; i--) begin
      if (press[i] && !wake) begin
        req_unit = 1'b1;
        unit_sel = tag_addr(i);
      end
    end

    // Change spacing: a new command only once the gap since the last one has run out.
    if (q.gap_busy) begin
      n.gap = q.gap + 1'b1;
      if (q.gap == GAP_CYC - 1) begin
        n.gap_busy = 1'b0;
      end
    end
    issue = (req_long || req_short || req_mode || req_unit) && !q.gap_busy;
    ev = '0;
    ev[`UCG_EV_REFUSED] = (req_long || req_short || req_mode || req_unit) && q.gap_busy;
    ev[`UCG_EV_CMD] = issue;

    n.cmd_valid = issue;
    n.cmd_mode_set = 1'b0;
    if (issue) begin
      n.gap = '0;
      n.gap_busy = 1'b1;
      n.cmd_all = 1'b0;
      n.cmd_heat = q.heat_mode;
      if (req_long) begin
        n.cmd_all = 1'b1;
        n.cmd_on = ~(|run_now);
      end else if (req_mode) begin
        n.heat_mode = ~q.heat_mode;
        n.cmd_heat = ~q.heat_mode;
        n.cmd_all = 1'b1;
        n.cmd_on = 1'b1;
        n.cmd_mode_set = 1'b1;
      end else if (req_short) begin
        n.cmd_addr = q.last_addr;
        n.cmd_on = ~run_now[q.last_addr];
      end else begin
        n.cmd_addr = unit_sel;
        n.last_addr = unit_sel;
        n.cmd_on = ~run_now[unit_sel];
      end
      // Presets are fixed here; no key path can alter them.
      n.cmd_setpoint = n.cmd_heat ? `UCG_HEAT_SP : `UCG_COOL_SP;
    end

    // Tag lights follow what the units report, so remote changes show at once; the group lights show heat_mode.
    n.heat_d = heat_now;
    n.fault_d = fault_now;
    ev[`UCG_EV_MODE] = |((heat_now ^ q.heat_d) & run_now);
    ev[`UCG_EV_FAULT] = |(fault_now & ~q.fault_d);
    if (q.dark) begin
      n.tag_blue = '0;
      n.tag_red = '0;
      n.grp_blue = 1'b0;
      n.grp_red = 1'b0;
      n.pwr_light = 1'b0;
    end else begin
      n.tag_blue = run_now & ~heat_now & ~fault_now;
      n.tag_red = (run_now & heat_now & ~fault_now) | (fault_now & {`UCG_NUNIT{q.flash}});
      n.grp_blue = ~q.heat_mode;
      n.grp_red = q.heat_mode;
      n.pwr_light = nvm_fault ? q.flash : (|run_now);
    end

    // Register port: one wait cycle, then the answer.
    // A write lands at the edge at which the master sees waitrequest low, never earlier.
    // Read data is captured one edge before that, so it already stands when the master takes it.
    n.ack = bus_req && !q.ack;
    n.status = q.status | ev;
    if (avs_write && q.ack && avs_byteenable[0]) begin
      if (sel(avs_address, `UCG_OFS_STATUS)) begin
        n.status = (q.status & ~avs_writedata[`UCG_NEV-1:0]) | ev;
      end
      if (sel(avs_address, `UCG_OFS_MASK)) begin
        n.mask = avs_writedata[`UCG_NEV-1:0];
      end
      if (sel(avs_address, `UCG_OFS_CONFIG)) begin
        n.sleep_en = avs_writedata[`UCG_CFG_SLEEP_EN];
      end
    end
    if (avs_read && !q.ack) begin
      n.rdata = '0;
      if (sel(avs_address, `UCG_OFS_STATUS)) begin
        n.rdata[`UCG_NEV-1:0] = q.status;
      end
      if (sel(avs_address, `UCG_OFS_MASK)) begin
        n.rdata[`UCG_NEV-1:0] = q.mask;
      end
      if (sel(avs_address, `UCG_OFS_CONFIG)) begin
        n.rdata[`UCG_CFG_SLEEP_EN] = q.sleep_en;
      end
      if (sel(avs_address, `UCG_OFS_STATE)) begin
        n.rdata[`UCG_AW-1:0] = q.last_addr;
        n.rdata[`UCG_ST_HEAT] = q.heat_mode;
        n.rdata[`UCG_ST_GAP] = q.gap_busy;
        n.rdata[`UCG_ST_DARK] = q.dark;
        n.rdata[`UCG_ST_NVM] = nvm_fault;
      end
      if (sel(avs_address, `UCG_OFS_UNITS)) begin
        n.rdata = {heat_now, run_now};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.gk <= GK_IDLE;
      q.sleep_en <= `UCG_CFG_RESET;
    end else begin
      q <= n;
    end
  end

  assign cmd_valid = q.cmd_valid;
  assign cmd_all = q.cmd_all;
  assign cmd_addr = q.cmd_addr;
  assign cmd_on = q.cmd_on;
  assign cmd_mode_set = q.cmd_mode_set;
  assign cmd_heat = q.cmd_heat;
  assign cmd_setpoint = q.cmd_setpoint;
  assign cmd_fan_high = 1'b1;
  assign tag_blue = q.tag_blue;
  assign tag_red = q.tag_red;
  assign grp_blue = q.grp_blue;
  assign grp_red = q.grp_red;
  assign pwr_light = q.pwr_light;
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = bus_req && !q.ack;
  assign irq = |(q.status & q.mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Unit status of the cycle in which a command was decided, one edge behind the command.
  // Commands are judged against it, because the units may already have answered by then.
  logic [`UCG_NUNIT-1:0] run_prev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_prev <= '0;
    end else begin
      run_prev <= run_now;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_bus_req;
    bus_req && avs_waitrequest;
  endsequence
  sequence s_bus_done;
    !avs_waitrequest;
  endsequence
  sequence s_quiet;
    !cmd_valid [*8];
  endsequence

  a_bus_answer: // bus
    assert property (s_bus_req |=> s_bus_done) else $error("bus answer late");
  a_cmd_gap:
    assert property (cmd_valid |-> !$past(q.gap_busy) && q.gap_busy) else $error("command inside gap");
  a_cmd_spacing:
    assert property (cmd_valid |=> s_quiet) else $error("commands too close");
  a_cool_preset:
    assert property (cmd_valid && !cmd_heat |-> cmd_setpoint == `UCG_COOL_SP && cmd_fan_high)
      else $error("bad cooling preset");
  a_heat_preset:
    assert property (cmd_valid && cmd_heat |-> cmd_setpoint == `UCG_HEAT_SP && cmd_fan_high)
      else $error("bad heating preset");
  a_group_mode:
    assert property (cmd_valid && cmd_mode_set |-> cmd_all && cmd_on && cmd_heat == q.heat_mode)
      else $error("group mode command wrong");
  a_unit_toggle:
    assert property (cmd_valid && !cmd_all |-> cmd_on == !run_prev[cmd_addr]) else $error("toggle wrong");
  a_tag_colour:
    assert property ((tag_blue & tag_red) == '0) else $error("tag both colours");
  // Lights follow the dark state one edge late, so the first dark edge is exempt.
  a_dark_leds:
    assert property (q.dark && $past(q.dark) |-> tag_blue == '0 && tag_red == '0 && !pwr_light)
      else $error("lights on while dark");
  // Every faulty unit, whichever it is, shows only the flash phase in red.
  a_fault_flash:
    assert property ($past(!q.dark) |-> (((tag_red ^ {`UCG_NUNIT{$past(q.flash)}}) & $past(fault_now)) == '0)
                     && ((tag_blue & $past(fault_now)) == '0))
      else $error("fault not flashing");
  a_nvm_flash:
    assert property ($past(!q.dark && nvm_fault) |-> pwr_light == $past(q.flash))
      else $error("memory fault not flashing");
  // A long press sends one command to every unit and turns them on only when none runs.
  a_long_toggle:
    assert property (cmd_valid && cmd_all && !cmd_mode_set |-> cmd_on == !(|run_prev))
      else $error("group toggle wrong");
  // Single-unit commands always go to the unit that was controlled most recently.
  a_short_last:
    assert property (cmd_valid && !cmd_all |-> cmd_addr == q.last_addr)
      else $error("single command to wrong unit");
  // A press that only wakes the lights must not reach the units.
  a_wake_quiet:
    assert property (wake |=> !cmd_valid) else $error("wake press issued a command");

endmodule : ucg_top

`default_nettype wire

/* File: verif/ucg_unit_model.sv */
// Behavioural model of the sixteen indoor unit boards on the controller's network.
// Assumes commands come on the controller clock, one per cmd_valid pulse.
`timescale 1ns/1ps
`default_nettype none
module ucg_unit_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic cmd_valid,
  input wire logic cmd_all,
  input wire logic [3:0] cmd_addr,
  input wire logic cmd_on,
  input wire logic cmd_mode_set,
  input wire logic cmd_heat,
  input wire logic [15:0] remote_flip,
  input wire logic [15:0] fault_in,
  output logic [15:0] unit_present,
  output logic [15:0] unit_running,
  output logic [15:0] unit_heat,
  output logic [15:0] unit_fault
);
  logic [7:0] pend;
  logic pend_v;
  logic [1:0] wait_cnt;
  // One board answers per address, so a duplicated address still shows as a single unit.
  assign unit_present = 16'hffff;
  assign unit_fault = fault_in;
  // A slow board applies a command three cycles late, as a busy main board would.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend <= 8'h00;
      pend_v <= 1'b0;
      wait_cnt <= 2'h0;
      unit_running <= 16'h0000;
      unit_heat <= 16'h0000;
    end else begin
      unit_heat <= unit_heat ^ remote_flip;
      if (cmd_valid) begin
        pend <= {cmd_all, cmd_addr, cmd_on, cmd_mode_set, cmd_heat};
        pend_v <= 1'b1;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end else if (pend_v && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (pend_v) begin
        pend_v <= 1'b0;
        if (pend[7] && pend[1]) begin
          unit_running <= 16'hffff;
          unit_heat <= {16{pend[0]}};
        end else if (pend[7]) begin
          unit_running <= {16{pend[2]}};
        end else begin
          unit_running[pend[6:3]] <= pend[2];
          if (pend[2]) unit_heat[pend[6:3]] <= pend[0];
        end
      end
    end
  end
endmodule : ucg_unit_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench of the group on/off controller with a model of the indoor units.
// Assumes ucg_defines.svh on the include path and short counts set by parameters.
`include "ucg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int GAP = 40;
  localparam int HOLD = 20;
  localparam int IDLE = 200;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] keys = '0;
  logic nvm_fault = 1'b0, slow = 1'b0;
  logic [15:0] flip = '0, fault_in = '0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = '0, avs_readdata, rng = 32'h0000_6d04;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, irq, cmd_valid, cmd_all, cmd_on, cmd_mode_set, cmd_heat, cmd_fan_high;
  logic [3:0] cmd_addr;
  logic [4:0] cmd_setpoint;
  logic [15:0] unit_present, unit_running, unit_heat, unit_fault, tag_blue, tag_red;
  logic grp_blue, grp_red, pwr_light;
  logic [27:0] cq[$];
  logic [63:0] rq[$];
  logic [27:0] e;
  logic [63:0] r;
  logic [1:0] seen;
  int miscompares = 0, checked = 0, cycles = 0, u;

  always #10 mclk = ~mclk;

  ucg_top #(.GAP_CYC(GAP), .HOLD_CYC(HOLD), .IDLE_CYC(IDLE), .FLASH_CYC(4)) dut (
    .mclk, .rst, .unit_key(keys[15:0]), .grp_pwr_key(keys[`UCG_KEY_GRP_PWR]),
    .grp_mode_key(keys[`UCG_KEY_GRP_MODE]), .unit_present, .unit_running, .unit_heat, .unit_fault,
    .nvm_fault, .cmd_valid, .cmd_all, .cmd_addr, .cmd_on, .cmd_mode_set, .cmd_heat, .cmd_setpoint,
    .cmd_fan_high, .tag_blue, .tag_red, .grp_blue, .grp_red, .pwr_light, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);
  ucg_unit_model model (.mclk, .rst, .slow, .cmd_valid, .cmd_all, .cmd_addr, .cmd_on, .cmd_mode_set,
    .cmd_heat, .remote_flip(flip), .fault_in, .unit_present, .unit_running, .unit_heat, .unit_fault);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    chk(cq.size() + rq.size(), 0);
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [13:0] cv(input logic all, input logic [3:0] a, input logic on, input logic ms,
                                     input logic h);
    return {all, a, on, ms, h, h ? 5'h1c : 5'h14, 1'b1};
  endfunction : cv

  // The request stays up until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
    rq.push_back({m, v});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Keys are held long enough to pass the synchroniser and the debounce agreement.
  task automatic press(input int k, input int n);
    @(posedge mclk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge mclk);
    keys[k] <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask : press

  task automatic flashes(input logic pwr);
    seen = 2'b00;
    repeat (16) begin
      @(posedge mclk);
      seen = seen | ((pwr ? pwr_light : tag_red[3]) ? 2'b10 : 2'b01);
    end
  endtask : flashes

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
    if (cmd_valid === 1'b1 && cq.size() == 0) chk(cmd_valid, 0);
    else if (cmd_valid === 1'b1) begin
      e = cq.pop_front();
      chk({cmd_all, cmd_addr, cmd_on, cmd_mode_set, cmd_heat, cmd_setpoint, cmd_fan_high} & e[27:14],
          e[13:0] & e[27:14]);
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() != 0) begin
      r = rq.pop_front();
      chk(avs_readdata & r[63:32], r[31:0] & r[63:32]);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(5'h04, 32'h0000_0000, 32'hffff_ffff);
    rd(5'h08, 32'h0000_0001, 32'h0000_0001);
    rd(5'h0c, 32'h0000_0000, 32'h0000_00ff);
    rd(5'h10, 32'h0000_0000, 32'hffff_ffff);
    rd(5'h1c, 32'h0000_0000, 32'hffff_ffff);
    rng = xs(rng);
    bus(1'b1, 5'h04, rng);
    rd(5'h04, rng & 32'h0000_000f, 32'hffff_ffff);
    bus(1'b1, 5'h04, 32'h0000_0001);
    bus(1'b1, 5'h00, 32'h0000_000f);
    avs_byteenable <= 4'he;
    bus(1'b1, 5'h08, 32'h0000_0000);
    avs_byteenable <= 4'hf;
    rd(5'h08, 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, 5'h08, 32'h0000_0000);
    rd(5'h08, 32'h0000_0000, 32'h0000_0001);
    bus(1'b1, 5'h08, 32'h0000_0001);
    rng = xs(rng);
    u = rng[3:0];
    cq.push_back({14'h3fff, cv(1'b0, u[3:0], 1'b1, 1'b0, 1'b0)});
    press(u, 6);
    chk(tag_blue[u], 1);
    chk(irq, 1);
    press(u, 6);
    rd(5'h00, 32'h0000_0003, 32'h0000_0003);
    bus(1'b1, 5'h00, 32'h0000_0003);
    @(posedge mclk);
    chk(irq, 0);
    repeat (GAP) @(posedge mclk);
    cq.push_back({14'h3fff, cv(1'b0, u[3:0], 1'b0, 1'b0, 1'b0)});
    press(u, 6);
    chk(tag_blue[u], 0);
    repeat (GAP) @(posedge mclk);
    slow <= 1'b1;
    cq.push_back({14'h3fff, cv(1'b0, 4'h5, 1'b1, 1'b0, 1'b0)});
    press(5, 6);
    slow <= 1'b0;
    chk(tag_blue[5], 1);
    repeat (GAP) @(posedge mclk);
    cq.push_back({14'h21ff, cv(1'b1, 4'h0, 1'b1, 1'b1, 1'b1)});
    press(`UCG_KEY_GRP_MODE, 6);
    chk({grp_red, grp_blue}, 2'b10);
    chk(tag_red, 16'hffff);
    @(posedge mclk);
    flip <= 16'h0020;
    @(posedge mclk);
    flip <= 16'h0000;
    repeat (4) @(posedge mclk);
    chk({tag_blue[5], tag_red[5]}, 2'b10);
    rd(5'h00, 32'h0000_0008, 32'h0000_0008);
    repeat (GAP) @(posedge mclk);
    cq.push_back({14'h3fff, cv(1'b0, 4'h5, 1'b0, 1'b0, 1'b1)});
    press(`UCG_KEY_GRP_PWR, 6);
    repeat (GAP) @(posedge mclk);
    cq.push_back({14'h2181, cv(1'b1, 4'h0, 1'b0, 1'b0, 1'b0)});
    press(`UCG_KEY_GRP_PWR, HOLD + 10);
    chk(tag_red, 16'h0000);
    repeat (GAP) @(posedge mclk);
    cq.push_back({14'h3fff, cv(1'b0, 4'h3, 1'b1, 1'b0, 1'b1)});
    press(3, 6);
    fault_in <= 16'h0008;
    flashes(1'b0);
    chk(seen, 2'b11);
    fault_in <= 16'h0000;
    nvm_fault <= 1'b1;
    flashes(1'b1);
    chk(seen, 2'b11);
    nvm_fault <= 1'b0;
    repeat (IDLE + 20) @(posedge mclk);
    chk(|{tag_blue, tag_red, grp_blue, grp_red, pwr_light}, 0);
    rd(5'h0c, 32'h0000_0040, 32'h0000_0040);
    press(3, 6);
    chk(tag_red[3], 1);
    cq.push_back({14'h21ff, cv(1'b1, 4'h0, 1'b1, 1'b1, 1'b0)});
    press(`UCG_KEY_GRP_MODE, 6);
    chk({grp_red, grp_blue}, 2'b01);
    chk(tag_blue, 16'hffff);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
